/* core/lcd_panel_mode_config.sv */
`timescale 1ns/1ps
module lcd_panel_mode_config
  import panel_mode_pkg::*;
#(
  parameter logic [5:0] PRODUCT_CODE = 6'h2A, // Arbitrary value.
  parameter logic [1:0] REVISION_CODE = 2'h2, // Arbitrary value.
  parameter int BUS_ADDR_W = ADDR_W,
  parameter int BUS_DATA_W = DATA_W
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Host memory-mapped port
  input wire logic CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic [BUS_ADDR_W-1:0] HOST_ADDRESS_BUS,
  input wire logic [BUS_DATA_W-1:0] HOST_DATA_IN,
  output logic [BUS_DATA_W-1:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE,
  // Raw timing from the panel timing generator, all active high
  input wire logic RAW_LINE_PULSE,
  input wire logic RAW_FRAME_PULSE,
  input wire logic RAW_SHIFT_CLOCK,
  input wire logic NON_DISPLAY,
  // Panel interface outputs
  output logic LINE_PULSE_OUT,
  output logic FRAME_PULSE_OUT,
  output logic PIXEL_SHIFT_CLOCK_OUT,
  // Decoded mode for the data path
  output logic PANEL_ACTIVE,
  output logic PANEL_DUAL,
  output logic PANEL_COLOR,
  output panel_format_t PANEL_FORMAT,
  output logic FORMAT_RESERVED
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (BUS_ADDR_W != ADDR_W) begin : g_bad_addr
    $error("Host address bus must be 16 bits wide.");
  end
  if (BUS_DATA_W != DATA_W) begin : g_bad_data
    $error("Host data bus must be 8 bits wide.");
  end

  // ---------------------------------------------------------------
  // Host access decode
  // ---------------------------------------------------------------
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic oe_r;
  logic in_window;
  logic host_read;
  logic host_write;
  logic hit_id;
  logic hit_mode;
  logic [7:0] id_byte;

  // The window is the top 32 bytes, so only the upper address bits need a compare.
  assign in_window = !CS_N && (HOST_ADDRESS_BUS[15:5] == REG_WINDOW_BASE[15:5]);
  assign host_read = in_window && !RD_N;
  assign host_write = in_window && !WR_N;
  assign hit_id = (HOST_ADDRESS_BUS == CHIP_ID_ADDR);
  assign hit_mode = (HOST_ADDRESS_BUS == PANEL_MODE_ADDR);
  assign id_byte = {PRODUCT_CODE, REVISION_CODE};

  // ---------------------------------------------------------------
  // Register write path
  // ---------------------------------------------------------------
  // Only the mode byte has storage; a write to the identification byte
  // or to an unused window address falls through without effect.
  assign mode_nxt = (host_write && hit_mode) ? HOST_DATA_IN : mode_r;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_r <= PANEL_MODE_RESET;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Register read path
  // ---------------------------------------------------------------
  assign rdata_nxt = !host_read ? READ_DATA_RESET :
                     hit_id ? id_byte :
                     hit_mode ? mode_r : UNMAPPED_READ;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_r <= READ_DATA_RESET;
      oe_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      oe_r <= host_read;
    end
  end

  assign HOST_DATA_OUT = rdata_r;
  assign HOST_DATA_OE = oe_r;

  // ---------------------------------------------------------------
  // Mode field decode
  // ---------------------------------------------------------------
  logic active_sel;
  logic dual_eff;
  logic color_eff;
  logic shift_masked;
  logic line_nxt;
  logic frame_nxt;
  logic shift_nxt;
  panel_format_t format_sel;

  assign active_sel = mode_r[MODE_ACTIVE_BIT];
  // Drive and colour fields are forced off for active panels so nothing downstream sees them.
  assign dual_eff = !active_sel && mode_r[MODE_DUAL_BIT];
  assign color_eff = !active_sel && mode_r[MODE_COLOR_BIT];
  assign shift_masked = color_eff || mode_r[MODE_SHIFT_MASK_BIT];

  panel_format_decoder u_format (
    .active_sel(active_sel),
    .dual_sel(mode_r[MODE_DUAL_BIT]),
    .color_sel(mode_r[MODE_COLOR_BIT]),
    .width_code(mode_r[MODE_WIDTH_MSB:MODE_WIDTH_LSB]),
    .format_sel(format_sel)
  );

  // ---------------------------------------------------------------
  // Panel pulse shaping
  // ---------------------------------------------------------------
  // Passive panels always see active-high pulses; the polarity bits only
  // bend the pulses of an active panel.
  assign line_nxt = active_sel ? (mode_r[MODE_LINE_POL_BIT] ? RAW_LINE_PULSE : !RAW_LINE_PULSE)
                               : RAW_LINE_PULSE;
  assign frame_nxt = active_sel ? (mode_r[MODE_FRAME_POL_BIT] ? RAW_FRAME_PULSE : !RAW_FRAME_PULSE)
                                : RAW_FRAME_PULSE;
  // Holding the clock low in blank time saves panel power at the cost of
  // no clock for panels that need it free running; software picks, except that passive colour panels always have it held low.
  assign shift_nxt = RAW_SHIFT_CLOCK && !(NON_DISPLAY && shift_masked);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      LINE_PULSE_OUT <= 1'b0;
      FRAME_PULSE_OUT <= 1'b0;
      PIXEL_SHIFT_CLOCK_OUT <= 1'b0;
    end else begin
      LINE_PULSE_OUT <= line_nxt;
      FRAME_PULSE_OUT <= frame_nxt;
      PIXEL_SHIFT_CLOCK_OUT <= shift_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Decoded mode outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PANEL_ACTIVE <= 1'b0;
      PANEL_DUAL <= 1'b0;
      PANEL_COLOR <= 1'b0;
      PANEL_FORMAT <= FMT_RESERVED;
      FORMAT_RESERVED <= 1'b0;
    end else begin
      PANEL_ACTIVE <= active_sel;
      PANEL_DUAL <= dual_eff;
      PANEL_COLOR <= color_eff;
      PANEL_FORMAT <= format_sel;
      // Reserved codes are flagged rather than trapped; the data path decides.
      FORMAT_RESERVED <= (format_sel == FMT_RESERVED);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic written_r;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      written_r <= 1'b0;
    end else if (host_write && hit_mode) begin
      written_r <= 1'b1;
    end
  end

  sequence s_id_read;
    !CS_N && !RD_N && HOST_ADDRESS_BUS == CHIP_ID_ADDR;
  endsequence

  sequence s_mode_write;
    !CS_N && !WR_N && HOST_ADDRESS_BUS == PANEL_MODE_ADDR;
  endsequence

  sequence s_mode_read;
    !CS_N && !RD_N && HOST_ADDRESS_BUS == PANEL_MODE_ADDR;
  endsequence

  a_reset_clear: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !written_r |-> mode_r == PANEL_MODE_RESET)
    else $error("Mode byte left reset value without a write.");

  // The decoded format lags the mode byte by one clock, so two quiet cycles are needed.
  a_reset_format: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !written_r ##1 !written_r |-> PANEL_FORMAT == FMT_MONO_SINGLE_4 && !FORMAT_RESERVED)
    else $error("Reset mode byte did not decode to the default format.");

  a_product_code: assert property (
    @(posedge CLK) disable iff (!RESETN)
    s_id_read |=> HOST_DATA_OUT[PRODUCT_MSB:PRODUCT_LSB] == PRODUCT_CODE && HOST_DATA_OE)
    else $error("Product code read back wrong.");

  a_revision_ro: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (!CS_N && !WR_N && HOST_ADDRESS_BUS == CHIP_ID_ADDR) |=> $stable(mode_r))
    else $error("Write to identification byte had an effect.");

  a_revision_code: assert property (
    @(posedge CLK) disable iff (!RESETN)
    s_id_read |=> HOST_DATA_OUT[REVISION_MSB:REVISION_LSB] == REVISION_CODE)
    else $error("Revision code read back wrong.");

  a_mode_write: assert property (
    @(posedge CLK) disable iff (!RESETN)
    s_mode_write |=> mode_r == $past(HOST_DATA_IN))
    else $error("Mode byte did not take the written value.");

  a_mode_readback: assert property (
    @(posedge CLK) disable iff (!RESETN)
    s_mode_read |=> HOST_DATA_OE && HOST_DATA_OUT == $past(mode_r))
    else $error("Mode byte did not read back its value.");

  a_unmapped_read: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (!CS_N && !RD_N && HOST_ADDRESS_BUS[15:5] == REG_WINDOW_BASE[15:5] && HOST_ADDRESS_BUS[4:1] != 4'h0)
      |=> HOST_DATA_OE && HOST_DATA_OUT == UNMAPPED_READ)
    else $error("Unused window address did not read as zero.");

  a_outside_window: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (CS_N || HOST_ADDRESS_BUS < REG_WINDOW_BASE) |=> !HOST_DATA_OE && $stable(mode_r))
    else $error("Register access outside the window.");

  a_active_ignore: assert property (
    @(posedge CLK) disable iff (!RESETN)
    mode_r[MODE_ACTIVE_BIT] |=> PANEL_ACTIVE && !PANEL_DUAL && !PANEL_COLOR)
    else $error("Drive or colour bit leaked in active mode.");

  a_line_polarity: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (mode_r[MODE_ACTIVE_BIT] && RAW_LINE_PULSE) |=> LINE_PULSE_OUT == $past(mode_r[MODE_LINE_POL_BIT]))
    else $error("Line pulse polarity wrong.");

  a_frame_polarity: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (!mode_r[MODE_ACTIVE_BIT] || mode_r[MODE_FRAME_POL_BIT]) |=> FRAME_PULSE_OUT == $past(RAW_FRAME_PULSE))
    else $error("Frame pulse polarity wrong.");

  a_shift_mask: assert property (
    @(posedge CLK) disable iff (!RESETN)
    NON_DISPLAY && (mode_r[MODE_SHIFT_MASK_BIT] || !mode_r[MODE_ACTIVE_BIT] && mode_r[MODE_COLOR_BIT])
      |=> !PIXEL_SHIFT_CLOCK_OUT)
    else $error("Shift clock not masked in blank time.");

  a_active_width: assert property (
    @(posedge CLK) disable iff (!RESETN)
    mode_r[MODE_ACTIVE_BIT]
      |=> PANEL_FORMAT == ($past(mode_r[MODE_WIDTH_LSB]) ? FMT_ACTIVE_12 : FMT_ACTIVE_9))
    else $error("Active panel width wrong.");

  a_mono_single: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (mode_r[7:5] == 3'h0 && mode_r[1:0] == WIDTH_CODE_1) |=> PANEL_FORMAT == FMT_MONO_SINGLE_8)
    else $error("Mono single 8-bit format wrong.");

  a_dual_select: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !mode_r[MODE_ACTIVE_BIT] |=> PANEL_DUAL == $past(mode_r[MODE_DUAL_BIT]))
    else $error("Passive panel drive selection wrong.");

  a_mono_dual: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (mode_r[7:5] == 3'h2 && mode_r[1:0] == WIDTH_CODE_1) |=> PANEL_FORMAT == FMT_MONO_DUAL_8)
    else $error("Mono dual 8-bit format wrong.");

  a_color_single: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (mode_r[7:5] == 3'h1 && mode_r[1:0] == WIDTH_CODE_3) |=> PANEL_FORMAT == FMT_COLOR_SINGLE_8_B)
    else $error("Colour single second 8-bit format wrong.");

  a_color_dual: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (mode_r[7:5] == 3'h3 && mode_r[1:0] == WIDTH_CODE_1) |=> PANEL_FORMAT == FMT_COLOR_DUAL_8)
    else $error("Colour dual 8-bit format wrong.");

endmodule // lcd_panel_mode_config

/* core/panel_format_decoder.sv */
`timescale 1ns/1ps
module panel_format_decoder
  import panel_mode_pkg::*;
(
  // Mode fields
  input wire logic active_sel,
  input wire logic dual_sel,
  input wire logic color_sel,
  input wire logic [1:0] width_code,
  // Decoded format
  output panel_format_t format_sel
);

  // ---------------------------------------------------------------
  // Format table
  // ---------------------------------------------------------------
  function automatic panel_format_t decode_format(input logic act, input logic dual, input logic col,
                                                  input logic [1:0] code);
    panel_format_t f;
    f = FMT_RESERVED;
    if (act) begin
      // Drive and colour fields do not matter for active panels.
      f = code[0] ? FMT_ACTIVE_12 : FMT_ACTIVE_9;
    end else if (!col && !dual) begin
      if (code == WIDTH_CODE_0) f = FMT_MONO_SINGLE_4;
      else if (code == WIDTH_CODE_1) f = FMT_MONO_SINGLE_8;
    end else if (!col && dual) begin
      if (code == WIDTH_CODE_1) f = FMT_MONO_DUAL_8;
    end else if (col && !dual) begin
      if (code == WIDTH_CODE_0) f = FMT_COLOR_SINGLE_4;
      else if (code == WIDTH_CODE_1) f = FMT_COLOR_SINGLE_8_A;
      else if (code == WIDTH_CODE_3) f = FMT_COLOR_SINGLE_8_B;
    end else begin
      if (code == WIDTH_CODE_1) f = FMT_COLOR_DUAL_8;
    end
    return f;
  endfunction

  assign format_sel = decode_format(active_sel, dual_sel, color_sel, width_code);

endmodule // panel_format_decoder

/* core/panel_mode_pkg.sv */
package panel_mode_pkg;

  // ---------------------------------------------------------------
  // Host window and register map
  // ---------------------------------------------------------------
  localparam logic [15:0] REG_WINDOW_BASE = 16'hFFE0;
  localparam logic [15:0] REG_WINDOW_LAST = 16'hFFFF;
  localparam logic [15:0] CHIP_ID_ADDR = 16'hFFE0;
  localparam logic [15:0] PANEL_MODE_ADDR = 16'hFFE1;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ---------------------------------------------------------------
  // Identification byte layout
  // ---------------------------------------------------------------
  localparam int PRODUCT_MSB = 7;
  localparam int PRODUCT_LSB = 2;
  localparam int REVISION_MSB = 1;
  localparam int REVISION_LSB = 0;

  // ---------------------------------------------------------------
  // Panel mode control layout and reset value
  // ---------------------------------------------------------------
  localparam int MODE_ACTIVE_BIT = 7;
  localparam int MODE_DUAL_BIT = 6;
  localparam int MODE_COLOR_BIT = 5;
  localparam int MODE_LINE_POL_BIT = 4;
  localparam int MODE_FRAME_POL_BIT = 3;
  localparam int MODE_SHIFT_MASK_BIT = 2;
  localparam int MODE_WIDTH_MSB = 1;
  localparam int MODE_WIDTH_LSB = 0;
  localparam logic [7:0] PANEL_MODE_RESET = 8'h00;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ---------------------------------------------------------------
  // Data width codes
  // ---------------------------------------------------------------
  localparam logic [1:0] WIDTH_CODE_0 = 2'h0;
  localparam logic [1:0] WIDTH_CODE_1 = 2'h1;
  localparam logic [1:0] WIDTH_CODE_3 = 2'h3;

  // ---------------------------------------------------------------
  // Decoded panel data formats
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    FMT_RESERVED = 4'h0,
    FMT_MONO_SINGLE_4 = 4'h1,
    FMT_MONO_SINGLE_8 = 4'h2,
    FMT_MONO_DUAL_8 = 4'h3,
    FMT_COLOR_SINGLE_4 = 4'h4,
    FMT_COLOR_SINGLE_8_A = 4'h5,
    FMT_COLOR_SINGLE_8_B = 4'h6,
    FMT_COLOR_DUAL_8 = 4'h7,
    FMT_ACTIVE_9 = 4'h8,
    FMT_ACTIVE_12 = 4'h9
  } panel_format_t;

endpackage

/* dv/lcd_panel_mode_config_test.sv */
`timescale 1ns/1ps
module lcd_panel_mode_config_test;
  import panel_mode_pkg::*;
  logic clk, resetn, cs_n, rd_n, wr_n;
  logic [15:0] addr;
  logic [7:0] din, dout;
  logic oe, rline, rframe, rshift, nd, line_o, frame_o, shift_o, act, dual, col, resv;
  panel_format_t fmt;
  int mismatches, compares, cycles, se, le, s0, l0;
  logic [7:0] m;
  logic r;

  lcd_panel_mode_config dut (.CLK(clk), .RESETN(resetn), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n),
    .HOST_ADDRESS_BUS(addr), .HOST_DATA_IN(din), .HOST_DATA_OUT(dout), .HOST_DATA_OE(oe),
    .RAW_LINE_PULSE(rline), .RAW_FRAME_PULSE(rframe), .RAW_SHIFT_CLOCK(rshift), .NON_DISPLAY(nd),
    .LINE_PULSE_OUT(line_o), .FRAME_PULSE_OUT(frame_o), .PIXEL_SHIFT_CLOCK_OUT(shift_o),
    .PANEL_ACTIVE(act), .PANEL_DUAL(dual), .PANEL_COLOR(col), .PANEL_FORMAT(fmt), .FORMAT_RESERVED(resv));
  lcd_panel_model panel (.clk(clk), .resetn(resetn), .line_in(line_o), .shift_in(shift_o),
    .shift_edges(se), .line_edges(le));

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One host cycle; a write expects a quiet data bus, a read the given byte.
  task automatic acc(input logic c, input logic wr, input logic [15:0] a, input logic [7:0] d,
                     input logic [7:0] exp, input logic exp_oe);
    @(posedge clk);
    #5;
    cs_n = c;
    wr_n = ~wr;
    rd_n = wr;
    addr = a;
    din = d;
    @(posedge clk);
    #1;
    chk(dout, exp);
    chk(8'(oe), 8'(exp_oe));
    #4;
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    din = ~d;
  endtask

  function automatic panel_format_t want(input logic [7:0] v);
    if (v[7]) return v[0] ? FMT_ACTIVE_12 : FMT_ACTIVE_9;
    case ({v[5], v[6], v[1:0]})
      4'b0000: return FMT_MONO_SINGLE_4;
      4'b0001: return FMT_MONO_SINGLE_8;
      4'b0101: return FMT_MONO_DUAL_8;
      4'b1000: return FMT_COLOR_SINGLE_4;
      4'b1001: return FMT_COLOR_SINGLE_8_A;
      4'b1011: return FMT_COLOR_SINGLE_8_B;
      4'b1101: return FMT_COLOR_DUAL_8;
      default: return FMT_RESERVED;
    endcase
  endfunction

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The ceiling is over thirty times the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {cs_n, rd_n, wr_n} = 3'b111;
    addr = 16'h0000;
    din = 8'h00;
    {rline, rframe, rshift, nd} = 4'h0;
    repeat (12) @(posedge clk);
    #5;
    resetn = 1'b1;
    acc(1'b0, 1'b0, 16'hFFE1, 8'h00, 8'h00, 1'b1);
    acc(1'b0, 1'b0, 16'hFFE0, 8'h00, 8'hAA, 1'b1);
    acc(1'b0, 1'b1, 16'hFFE0, 8'h55, 8'h00, 1'b0);
    acc(1'b0, 1'b0, 16'hFFE0, 8'h00, 8'hAA, 1'b1);
    acc(1'b1, 1'b1, 16'hFFE1, 8'hFF, 8'h00, 1'b0);
    acc(1'b0, 1'b1, 16'hFFDF, 8'hFF, 8'h00, 1'b0);
    acc(1'b0, 1'b1, 16'hFFE5, 8'hFF, 8'h00, 1'b0);
    acc(1'b1, 1'b0, 16'hFFE0, 8'h00, 8'h00, 1'b0);
    acc(1'b0, 1'b0, 16'hFFDF, 8'h00, 8'h00, 1'b0);
    acc(1'b0, 1'b0, 16'hFFFF, 8'h00, 8'h00, 1'b1);
    acc(1'b0, 1'b0, 16'hFFE1, 8'h00, 8'h00, 1'b1);
    // Every format code, reserved ones included, with the polarity bits varied alongside.
    for (int i = 0; i < 32; i++) begin
      m = {i[4:2], i[2:0], i[1:0]};
      acc(1'b0, 1'b1, 16'hFFE1, m, 8'h00, 1'b0);
      @(posedge clk);
      #1;
      chk(8'(fmt), 8'(want(m)));
      chk(8'(resv), 8'(want(m) == FMT_RESERVED));
      chk({act, dual, col}, {5'h00, m[7], m[6] & ~m[7], m[5] & ~m[7]});
      acc(1'b0, 1'b0, 16'hFFE1, 8'h00, m, 1'b1);
    end
    // Pulse polarity and shift clock masking over all controlling bits.
    rshift = 1'b1;
    for (int k = 0; k < 64; k++) begin
      m = {k[5], 1'b0, k[4:1], 2'b01};
      acc(1'b0, 1'b1, 16'hFFE1, m, 8'h00, 1'b0);
      for (int j = 0; j < 2; j++) begin
        r = j[0];
        @(posedge clk);
        #5;
        rline = r;
        rframe = ~r;
        nd = k[0];
        @(posedge clk);
        #1;
        // Concatenation keeps the single-bit inversions from widening.
        chk({7'h00, line_o}, {7'h00, (k[5] ? (k[3] ? r : ~r) : r)});
        chk({7'h00, frame_o}, {7'h00, (k[5] ? (k[2] ? ~r : r) : ~r)});
        chk({7'h00, shift_o}, {7'h00, ~(k[0] & (k[1] | (k[4] & ~k[5])))});
      end
    end
    // Four shift clock and line pulse cycles in display time must all reach the panel.
    acc(1'b0, 1'b1, 16'hFFE1, 8'h24, 8'h00, 1'b0);
    nd = 1'b0;
    s0 = se;
    l0 = le;
    repeat (4) begin
      rshift = 1'b0;
      rline = 1'b0;
      @(posedge clk);
      #5;
      rshift = 1'b1;
      rline = 1'b1;
      @(posedge clk);
      #5;
    end
    repeat (3) @(posedge clk);
    #1;
    chk(8'(se - s0), 8'h04);
    chk(8'(le - l0), 8'h04);
    // A reset in mid-run must bring the mode byte back to its reset value.
    @(posedge clk);
    #5;
    resetn = 1'b0;
    repeat (2) @(posedge clk);
    #5;
    resetn = 1'b1;
    acc(1'b0, 1'b0, 16'hFFE1, 8'h00, 8'h00, 1'b1);
    chk(8'(fmt), 8'(FMT_MONO_SINGLE_4));
    close_out();
  end
endmodule // lcd_panel_mode_config_test

/* dv/lcd_panel_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Panel side: counts shift clock and line pulse edges it receives
// ---------------------------------------------------------------
module lcd_panel_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Panel interface
  input wire logic line_in,
  input wire logic shift_in,
  // Observed counts
  output int shift_edges,
  output int line_edges
);
  logic shift_r;
  logic line_r;
  // A real panel latches data on shift clock edges, so a masked clock shows as missing edges.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_r <= 1'b0;
      line_r <= 1'b0;
      shift_edges <= 0;
      line_edges <= 0;
    end else begin
      shift_r <= shift_in;
      line_r <= line_in;
      if (shift_in && !shift_r) shift_edges <= shift_edges + 1;
      if (line_in && !line_r) line_edges <= line_edges + 1;
    end
  end
endmodule // lcd_panel_model
